// >>> rtl/lsar_defines.vh
// Register map, field positions, reset values and timing for the load switch and converter registers
`ifndef LSAR_DEFINES_VH
`define LSAR_DEFINES_VH

// ==================================================
// Register offsets
`define LSAR_ADDR_SW7      8'h15
`define LSAR_ADDR_ADCTL    8'h16
`define LSAR_ADDR_RESLO    8'h17
`define LSAR_ADDR_RESHI    8'h18
`define LSAR_ADDR_SPARE    8'h1b

// ==================================================
// Switch seven control fields
`define LSAR_SW7_TO        7
`define LSAR_SW7_OC        6
`define LSAR_SW7_OT        5
`define LSAR_SW7_PG        4
`define LSAR_SW7_WT_HI     3
`define LSAR_SW7_WT_LO     2
`define LSAR_SW7_ADIS      1
`define LSAR_SW7_EN        0
`define LSAR_SW7_CTL_RST   4'h2

// ==================================================
// Converter control fields
`define LSAR_AD_START      6
`define LSAR_AD_EOC        5
`define LSAR_AD_REF        4
`define LSAR_AD_CH_HI      3
`define LSAR_AD_CH_LO      0
`define LSAR_AD_CH_RST     4'h0
`define LSAR_AD_EOC_RST    1'b1
`define LSAR_CH_GAP        4'hb
`define LSAR_CH_LAST       4'hd
`define LSAR_RES_W         10
`define LSAR_RES_LO_W      8

// ==================================================
// Spare register fields
`define LSAR_SP_RELOAD     7
`define LSAR_SPARE_RST     7'h00

// ==================================================
// Serial port
`define LSAR_I2C_ADDR_DEF  7'h2a
`define LSAR_BYTE_BITS     4'h8
`define LSAR_SYNC_RST      6'h30

// ==================================================
// Timing
`define LSAR_CLK_MHZ       40
`define LSAR_WAIT0_US      200
`define LSAR_WAIT1_US      800
`define LSAR_WAIT2_US      1600
`define LSAR_WAIT3_US      3200
`define LSAR_TMR_W         18

`endif

// >>> rtl/lsar_conv_seq.v
// Conversion sequencer for the monitoring converter
`timescale 1ns/1ps
`default_nettype none
`include "lsar_defines.vh"

module lsar_conv_seq (
    input  wire                   clk_sys,
    input  wire                   sys_rst,
    input  wire                   startPulse,
    input  wire [3:0]             channelSel,
    input  wire                   convAck,
    input  wire [`LSAR_RES_W-1:0] convDataIn,
    output wire                   convReq,
    output wire [3:0]             convChannel,
    output wire                   donePulse,
    output wire [`LSAR_RES_W-1:0] convResult
);

    localparam SQ_IDLE = 1'b0;
    localparam SQ_BUSY = 1'b1;

    reg                   state_r;
    reg                   req_r;
    reg                   done_r;
    reg [3:0]             chan_r;
    reg [`LSAR_RES_W-1:0] result_r;

    wire chUnused = (channelSel == `LSAR_CH_GAP) || (channelSel > `LSAR_CH_LAST);

    // ==================================================
    // Sequence
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r  <= SQ_IDLE;
            req_r    <= 1'b0;
            done_r   <= 1'b0;
            chan_r   <= `LSAR_AD_CH_RST;
            result_r <= {`LSAR_RES_W{1'b0}};
        end else begin
            done_r <= 1'b0;
            case (state_r)
                SQ_IDLE: begin
                    if (startPulse) begin
                        chan_r <= channelSel;
                        if (chUnused) begin
                            result_r <= {`LSAR_RES_W{1'b0}};
                            done_r   <= 1'b1;
                        end else begin
                            req_r   <= 1'b1;
                            state_r <= SQ_BUSY;
                        end
                    end
                end
                SQ_BUSY: begin
                    if (convAck) begin
                        req_r    <= 1'b0;
                        result_r <= convDataIn;
                        done_r   <= 1'b1;
                        state_r  <= SQ_IDLE;
                    end
                end
                default: begin
                    state_r <= SQ_IDLE;
                end
            endcase
        end
    end

    assign convReq     = req_r;
    assign convChannel = chan_r;
    assign donePulse   = done_r;
    assign convResult  = result_r;

endmodule // lsar_conv_seq
`default_nettype wire

// >>> rtl/lsar_regs.v
// Switch seven, converter and spare registers behind a serial slave port
`timescale 1ns/1ps
`default_nettype none
`include "lsar_defines.vh"

module lsar_regs #(
    parameter [6:0]             SLAVE_ADDR = `LSAR_I2C_ADDR_DEF,
    parameter [`LSAR_TMR_W-1:0] WAIT0_CYC  = `LSAR_WAIT0_US * `LSAR_CLK_MHZ,
    parameter [`LSAR_TMR_W-1:0] WAIT1_CYC  = `LSAR_WAIT1_US * `LSAR_CLK_MHZ,
    parameter [`LSAR_TMR_W-1:0] WAIT2_CYC  = `LSAR_WAIT2_US * `LSAR_CLK_MHZ,
    parameter [`LSAR_TMR_W-1:0] WAIT3_CYC  = `LSAR_WAIT3_US * `LSAR_CLK_MHZ
) (
    input  wire                   clk_sys,
    input  wire                   sys_rst,
    input  wire                   sclIn,
    input  wire                   sdaIn,
    output wire                   sdaOut,
    output wire                   sdaOeN,
    input  wire                   sw7CurLimitIn,
    input  wire                   sw7OvercurrentIn,
    input  wire                   sw7OvertempIn,
    input  wire                   sw7PowerGoodIn,
    output wire                   sw7Enable,
    output wire                   sw7AutoDischargeEn,
    output wire [1:0]             sw7LimitWaitSel,
    output wire                   convRefEnable,
    output wire                   convReq,
    output wire [3:0]             convChannel,
    input  wire                   convAck,
    input  wire [`LSAR_RES_W-1:0] convDataIn
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RD   = 3'h5;
    localparam ST_RACK = 3'h6;

    // ==================================================
    // Input synchronisers
    reg  [5:0] syncA_r;
    reg  [5:0] syncB_r;
    reg        sclPrev_r;
    reg        sdaPrev_r;
    wire [5:0] asyncIn = {sclIn, sdaIn, sw7CurLimitIn, sw7OvercurrentIn, sw7OvertempIn, sw7PowerGoodIn};

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            syncA_r   <= `LSAR_SYNC_RST;
            syncB_r   <= `LSAR_SYNC_RST;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            syncA_r   <= asyncIn;
            syncB_r   <= syncA_r;
            sclPrev_r <= syncB_r[5];
            sdaPrev_r <= syncB_r[4];
        end
    end

    wire sclS     = syncB_r[5];
    wire sdaS     = syncB_r[4];
    wire curLimS  = syncB_r[3];
    wire ocS      = syncB_r[2];
    wire otS      = syncB_r[1];
    wire pgS      = syncB_r[0];
    wire sclRise  = sclS & ~sclPrev_r;
    wire sclFall  = ~sclS & sclPrev_r;
    wire startDet = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
    wire stopDet  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

    // ==================================================
    // Serial slave
    reg [2:0] state_r;
    reg [3:0] bitCnt_r;
    reg [7:0] rxShift_r;
    reg [7:0] txShift_r;
    reg [7:0] ptr_r;
    reg       rdMode_r;
    reg       firstByte_r;
    reg       nack_r;
    reg       sdaDrv_r;
    reg       wrEn_r;
    reg [7:0] rdData;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r     <= ST_IDLE;
            bitCnt_r    <= 4'h0;
            rxShift_r   <= 8'h00;
            txShift_r   <= 8'h00;
            ptr_r       <= 8'h00;
            rdMode_r    <= 1'b0;
            firstByte_r <= 1'b0;
            nack_r      <= 1'b0;
            sdaDrv_r    <= 1'b0;
            wrEn_r      <= 1'b0;
        end else begin
            wrEn_r <= 1'b0;
            if (startDet) begin
                state_r  <= ST_ADDR;
                bitCnt_r <= 4'h0;
                sdaDrv_r <= 1'b0;
            end else if (stopDet) begin
                state_r  <= ST_IDLE;
                sdaDrv_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_ADDR, ST_WR: begin
                        if (sclRise) begin
                            rxShift_r <= {rxShift_r[6:0], sdaS};
                            bitCnt_r  <= bitCnt_r + 4'h1;
                        end else if (sclFall && bitCnt_r == `LSAR_BYTE_BITS) begin
                            if (state_r == ST_ADDR) begin
                                if (rxShift_r[7:1] == SLAVE_ADDR) begin
                                    rdMode_r <= rxShift_r[0];
                                    sdaDrv_r <= 1'b1;
                                    state_r  <= ST_AACK;
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end else begin
                                sdaDrv_r <= 1'b1;
                                state_r  <= ST_WACK;
                                if (firstByte_r) begin
                                    ptr_r <= rxShift_r;
                                end else begin
                                    wrEn_r <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (sclRise) begin
                            nack_r <= sdaS;
                        end else if (sclFall) begin
                            bitCnt_r <= 4'h0;
                            if (state_r == ST_RACK && nack_r) begin
                                sdaDrv_r <= 1'b0;
                                state_r  <= ST_IDLE;
                            end else if (rdMode_r) begin
                                txShift_r <= rdData;
                                sdaDrv_r  <= ~rdData[7];
                                state_r   <= ST_RD;
                            end else begin
                                sdaDrv_r    <= 1'b0;
                                firstByte_r <= 1'b1;
                                state_r     <= ST_WR;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (sclFall) begin
                            sdaDrv_r    <= 1'b0;
                            bitCnt_r    <= 4'h0;
                            firstByte_r <= 1'b0;
                            if (!firstByte_r) begin
                                ptr_r <= ptr_r + 8'h01;
                            end
                            state_r <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (sclRise) begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall) begin
                            if (bitCnt_r == `LSAR_BYTE_BITS) begin
                                sdaDrv_r <= 1'b0;
                                ptr_r    <= ptr_r + 8'h01;
                                state_r  <= ST_RACK;
                            end else begin
                                txShift_r <= {txShift_r[6:0], 1'b0};
                                sdaDrv_r  <= ~txShift_r[6];
                            end
                        end
                    end
                    default: begin
                        sdaDrv_r <= 1'b0;
                        state_r  <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOeN = ~sdaDrv_r;

    // ==================================================
    // Write decode
    wire [7:0] wrData  = rxShift_r;
    wire       wrSw7   = wrEn_r && (ptr_r == `LSAR_ADDR_SW7);
    wire       wrAd    = wrEn_r && (ptr_r == `LSAR_ADDR_ADCTL);
    wire       wrSpare = wrEn_r && (ptr_r == `LSAR_ADDR_SPARE);

    // ==================================================
    // Register contents
    reg [3:0]             sw7Ctl_r;
    reg                   timeout_r;
    reg                   switchOn_r;
    reg [`LSAR_TMR_W-1:0] waitCnt_r;
    reg [`LSAR_TMR_W-1:0] waitTarget;
    reg [3:0]             convCh_r;
    reg                   convRef_r;
    reg                   convStart_r;
    reg                   convDone_r;
    reg [6:0]             userSpareBits_r;
    reg                   reload_r;
    wire                  seqDone;
    wire [`LSAR_RES_W-1:0] convResult;

    wire startReq = wrAd && wrData[`LSAR_AD_START] && !convStart_r;
    wire timerHit = sw7Ctl_r[`LSAR_SW7_EN] && !timeout_r && curLimS && (waitCnt_r == waitTarget - 1'b1);

    always @* begin
        case (sw7Ctl_r[`LSAR_SW7_WT_HI:`LSAR_SW7_WT_LO])
            2'h0:    waitTarget = WAIT0_CYC;
            2'h1:    waitTarget = WAIT1_CYC;
            2'h2:    waitTarget = WAIT2_CYC;
            default: waitTarget = WAIT3_CYC;
        endcase
    end

    always @(posedge clk_sys) begin
        if (sys_rst || reload_r) begin
            sw7Ctl_r        <= `LSAR_SW7_CTL_RST;
            timeout_r       <= 1'b0;
            waitCnt_r       <= {`LSAR_TMR_W{1'b0}};
            switchOn_r      <= 1'b0;
            convCh_r        <= `LSAR_AD_CH_RST;
            convRef_r       <= 1'b0;
            convStart_r     <= 1'b0;
            convDone_r      <= `LSAR_AD_EOC_RST;
            userSpareBits_r <= `LSAR_SPARE_RST;
        end else begin
            if (wrSw7) begin
                sw7Ctl_r <= wrData[`LSAR_SW7_WT_HI:`LSAR_SW7_EN];
            end
            if (sw7Ctl_r[`LSAR_SW7_EN] && !timeout_r && curLimS) begin
                waitCnt_r <= waitCnt_r + 1'b1;
            end else begin
                waitCnt_r <= {`LSAR_TMR_W{1'b0}};
            end
            if (timerHit) begin
                timeout_r <= 1'b1;
            end else if (wrSw7 && !wrData[`LSAR_SW7_EN]) begin
                timeout_r <= 1'b0;
            end
            switchOn_r <= sw7Ctl_r[`LSAR_SW7_EN] && !timeout_r && !timerHit;
            if (wrAd) begin
                convRef_r <= wrData[`LSAR_AD_REF];
                convCh_r  <= wrData[`LSAR_AD_CH_HI:`LSAR_AD_CH_LO];
            end
            if (startReq) begin
                convStart_r <= 1'b1;
            end else if (seqDone) begin
                convStart_r <= 1'b0;
            end
            if (seqDone) begin
                convDone_r <= 1'b1;
            end else if (startReq) begin
                convDone_r <= 1'b0;
            end
            if (wrSpare) begin
                userSpareBits_r <= wrData[6:0];
            end
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            reload_r <= 1'b0;
        end else begin
            reload_r <= wrSpare && wrData[`LSAR_SP_RELOAD] && !reload_r;
        end
    end

    // ==================================================
    // Conversion sequencer
    lsar_conv_seq u_seq (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .startPulse  (startReq),
        .channelSel  (wrData[`LSAR_AD_CH_HI:`LSAR_AD_CH_LO]),
        .convAck     (convAck),
        .convDataIn  (convDataIn),
        .convReq     (convReq),
        .convChannel (convChannel),
        .donePulse   (seqDone),
        .convResult  (convResult)
    );

    // ==================================================
    // Read mux
    always @* begin
        rdData = 8'h00;
        case (ptr_r)
            `LSAR_ADDR_SW7: begin
                rdData = {timeout_r, ocS, otS, pgS, sw7Ctl_r};
            end
            `LSAR_ADDR_ADCTL: begin
                rdData = {1'b0, convStart_r, convDone_r, convRef_r, convCh_r};
            end
            `LSAR_ADDR_RESLO: begin
                rdData = convResult[`LSAR_RES_LO_W-1:0];
            end
            `LSAR_ADDR_RESHI: begin
                rdData = {6'h00, convResult[`LSAR_RES_W-1:`LSAR_RES_LO_W]};
            end
            `LSAR_ADDR_SPARE: begin
                rdData = {reload_r, userSpareBits_r};
            end
            default: begin
                rdData = 8'h00;
            end
        endcase
    end

    assign sw7Enable          = switchOn_r;
    assign sw7AutoDischargeEn = sw7Ctl_r[`LSAR_SW7_ADIS];
    assign sw7LimitWaitSel    = sw7Ctl_r[`LSAR_SW7_WT_HI:`LSAR_SW7_WT_LO];
    assign convRefEnable      = convRef_r;

endmodule // lsar_regs
`default_nettype wire

// >>> testbench/lsar_regs_properties.sv
// Concurrent checks on the register block ports
`timescale 1ns/1ps
`default_nettype none
module lsar_regs_properties #(
    parameter [17:0] WAIT0_CYC = 18'd8000,
    parameter [17:0] WAIT1_CYC = 18'd32000,
    parameter [17:0] WAIT2_CYC = 18'd64000,
    parameter [17:0] WAIT3_CYC = 18'd128000
) (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOeN,
    input wire logic       sw7CurLimitIn,
    input wire logic       sw7OvercurrentIn,
    input wire logic       sw7OvertempIn,
    input wire logic       sw7PowerGoodIn,
    input wire logic       sw7Enable,
    input wire logic       sw7AutoDischargeEn,
    input wire logic [1:0] sw7LimitWaitSel,
    input wire logic       convRefEnable,
    input wire logic       convReq,
    input wire logic [3:0] convChannel,
    input wire logic       convAck,
    input wire logic [9:0] convDataIn
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ==========
    // Limit time counter
    logic [17:0] limCnt;
    logic [17:0] waitCyc;
    always_comb begin
        case (sw7LimitWaitSel)
            2'h0: waitCyc = WAIT0_CYC;
            2'h1: waitCyc = WAIT1_CYC;
            2'h2: waitCyc = WAIT2_CYC;
            default: waitCyc = WAIT3_CYC;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !sw7Enable || !sw7CurLimitIn) limCnt <= 18'h0;
        else if (limCnt != 18'h3ffff) limCnt <= limCnt + 18'h1;
    end
    sequence convHandshake;
        convReq && convAck;
    endsequence
    sequence reqReleased;
        !convReq ##1 !convReq;
    endsequence
    // ==========
    // Properties
    AST_RESET_VAL: assert property (disable iff (1'b0) $fell(sys_rst) |-> sdaOeN && !sw7Enable
        && sw7AutoDischargeEn && sw7LimitWaitSel == 2'h0 && !convRefEnable && !convReq && convChannel == 4'h0)
        else $error("outputs not at reset values");
    AST_REQ_HOLD: assert property (convReq && !convAck |=> convReq)
        else $error("request dropped before acknowledge");
    AST_REQ_DROP: assert property (convHandshake |=> reqReleased)
        else $error("request held after acknowledge");
    AST_REQ_GAP: assert property ($fell(convReq) |-> !convReq [*8])
        else $error("request restarted without a write");
    AST_CHAN_STABLE: assert property (convReq |=> !convReq || $stable(convChannel))
        else $error("channel changed during conversion");
    AST_CHAN_USED: assert property ($rose(convReq) |-> convChannel != 4'hb && convChannel <= 4'hd)
        else $error("conversion of unused channel");
    AST_TIMEOUT: assert property (limCnt > waitCyc + 18'd8 |-> !sw7Enable)
        else $error("switch still on after limit time");
    AST_TO_HOLD: assert property ($fell(sw7Enable) |=> !sw7Enable [*8])
        else $error("switch came back without a write");
endmodule // lsar_regs_properties
`default_nettype wire

// >>> testbench/lsar_host_model.sv
// Serial bus master standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module lsar_host_model #(
    parameter [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic clk_sys,
    input  wire logic sdaBus,
    output var  logic sclDrv,
    output var  logic sdaDrv
);
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end
    // ==========
    // Bus phases, quarter link period is two clocks
    task automatic q();
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic start_bit();
        sdaDrv <= 1'b1;
        q();
        q();
        sclDrv <= 1'b1;
        q();
        sdaDrv <= 1'b0;
        q();
        sclDrv <= 1'b0;
        q();
    endtask
    task automatic stop_bit();
        sdaDrv <= 1'b0;
        q();
        sclDrv <= 1'b1;
        q();
        sdaDrv <= 1'b1;
        q();
    endtask
    task automatic bit_x(input logic b, output logic r);
        sdaDrv <= b;
        q();
        sclDrv <= 1'b1;
        q();
        q();
        r = sdaBus;
        sclDrv <= 1'b0;
        q();
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ackOut, output logic [7:0] r, output logic ackIn);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(ackOut, ackIn);
    endtask
    // ==========
    // Register transfers
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic nack);
        logic [7:0] r;
        logic       n0, n1, n2;
        start_bit();
        xbyte({DEV_ADDR, 1'b0}, 1'b1, r, n0);
        xbyte(a, 1'b1, r, n1);
        xbyte(d, 1'b1, r, n2);
        stop_bit();
        nack = n0 | n1 | n2;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic nack);
        logic [7:0] r;
        logic       n0, n1, n2, n3;
        start_bit();
        xbyte({DEV_ADDR, 1'b0}, 1'b1, r, n0);
        xbyte(a, 1'b1, r, n1);
        start_bit();
        xbyte({DEV_ADDR, 1'b1}, 1'b1, r, n2);
        xbyte(8'hff, 1'b1, d, n3);
        stop_bit();
        nack = n0 | n1 | n2;
    endtask
endmodule // lsar_host_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the switch seven, converter and spare registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk_sys;
    logic       sys_rst;
    logic       sclDrv;
    logic       sdaDrv;
    logic       sdaWire;
    logic       sdaOut;
    logic       sdaOeN;
    logic       sw7CurLimitIn;
    logic [2:0] flagVec;
    logic       sw7Enable;
    logic       sw7AutoDischargeEn;
    logic [1:0] sw7LimitWaitSel;
    logic       convRefEnable;
    logic       convReq;
    logic [3:0] convChannel;
    logic       convAck;
    logic [9:0] convDataIn;
    logic [9:0] res;
    int         convDelay;
    int         convWait;
    int         cycCnt;
    int         error_cnt;
    int         samples_checked;
    assign sdaWire = sdaDrv & (sdaOeN | sdaOut);
    lsar_host_model u_host (.clk_sys(clk_sys), .sdaBus(sdaWire), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
    lsar_regs #(.WAIT0_CYC(18'd20), .WAIT1_CYC(18'd40), .WAIT2_CYC(18'd60), .WAIT3_CYC(18'd80)) u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclDrv), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .sw7CurLimitIn(sw7CurLimitIn), .sw7OvercurrentIn(flagVec[2]),
        .sw7OvertempIn(flagVec[1]), .sw7PowerGoodIn(flagVec[0]), .sw7Enable(sw7Enable),
        .sw7AutoDischargeEn(sw7AutoDischargeEn), .sw7LimitWaitSel(sw7LimitWaitSel),
        .convRefEnable(convRefEnable), .convReq(convReq), .convChannel(convChannel),
        .convAck(convAck), .convDataIn(convDataIn));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycCnt <= cycCnt + 1;
        if (cycCnt == 80000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ==========
    // Converter stand-in, data scrambled outside the answer
    always @(posedge clk_sys) begin
        convAck <= 1'b0;
        convDataIn <= ~{convChannel, 6'h2d};
        if (convReq && !convAck) begin
            convWait <= convWait + 1;
            if (convWait >= convDelay) begin
                convAck <= 1'b1;
                convDataIn <= {convChannel, 6'h2d};
                convWait <= 0;
            end
        end
    end
    // ==========
    // Checking and access tasks
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrc(input logic [7:0] a, input logic [7:0] d);
        logic n;
        u_host.wr_reg(a, d, n);
        chk({9'h0, n}, 10'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       n;
        u_host.rd_reg(a, d, n);
        chk({2'h0, d}, {2'h0, e});
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 1000 && convReq; k++) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        sw7CurLimitIn = 1'b0;
        flagVec = 3'h0;
        convDelay = 0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rdc(8'h15, 8'h02);
        rdc(8'h16, 8'h20);
        rdc(8'h17, 8'h00);
        rdc(8'h18, 8'h00);
        rdc(8'h1b, 8'h00);
        for (int i = 4; i < 7; i++) begin
            flagVec <= 3'(1 << (i - 4));
            rdc(8'h15, 8'h02 | 8'(1 << i));
        end
        flagVec <= 3'h0;
        for (int s = 0; s < 4; s++) begin
            wrc(8'h15, {4'h0, s[1:0], 2'b01});
            repeat (2) @(posedge clk_sys);
            chk({8'h0, sw7LimitWaitSel}, {8'h0, s[1:0]});
            chk({8'h0, sw7AutoDischargeEn, sw7Enable}, 10'h1);
            sw7CurLimitIn <= 1'b1;
            repeat (20 * (s + 1) - 2) @(posedge clk_sys);
            chk({9'h0, sw7Enable}, 10'h1);
            repeat (12) @(posedge clk_sys);
            chk({9'h0, sw7Enable}, 10'h0);
            sw7CurLimitIn <= 1'b0;
            rdc(8'h15, {4'h8, s[1:0], 2'b01});
            wrc(8'h15, {4'h0, s[1:0], 2'b10});
            rdc(8'h15, {4'h0, s[1:0], 2'b10});
        end
        for (int c = 15; c >= 0; c--) begin
            convDelay <= (c == 3) ? 800 : ((c == 0) ? 0 : 40);
            res = (c == 11 || c >= 14) ? 10'h0 : {c[3:0], 6'h2d};
            wrc(8'h16, {4'h5, c[3:0]});
            if (c != 0) chk({5'h0, convReq, convChannel}, {5'h0, res != 10'h0, c[3:0]});
            if (c == 3) rdc(8'h16, 8'h53);
            wait_idle();
            chk({9'h0, convRefEnable}, 10'h1);
            rdc(8'h16, {4'h3, c[3:0]});
            rdc(8'h17, res[7:0]);
            rdc(8'h18, {6'h0, res[9:8]});
        end
        wrc(8'h16, 8'h0a);
        chk({9'h0, convRefEnable}, 10'h0);
        rdc(8'h16, 8'h2a);
        wrc(8'h1b, 8'h55);
        rdc(8'h1b, 8'h55);
        wrc(8'h15, 8'h0d);
        wrc(8'h1b, 8'hd5);
        rdc(8'h1b, 8'h00);
        rdc(8'h15, 8'h02);
        rdc(8'h16, 8'h20);
        rdc(8'h17, 8'h2d);
        chk({9'h0, sw7Enable}, 10'h0);
        end_of_test();
    end
endmodule // testbench
bind lsar_regs lsar_regs_properties #(
    .WAIT0_CYC(WAIT0_CYC), .WAIT1_CYC(WAIT1_CYC), .WAIT2_CYC(WAIT2_CYC), .WAIT3_CYC(WAIT3_CYC)
) u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .sw7CurLimitIn(sw7CurLimitIn), .sw7OvercurrentIn(sw7OvercurrentIn), .sw7OvertempIn(sw7OvertempIn),
    .sw7PowerGoodIn(sw7PowerGoodIn), .sw7Enable(sw7Enable), .sw7AutoDischargeEn(sw7AutoDischargeEn),
    .sw7LimitWaitSel(sw7LimitWaitSel), .convRefEnable(convRefEnable), .convReq(convReq),
    .convChannel(convChannel), .convAck(convAck), .convDataIn(convDataIn));
`default_nettype wire
